//--- shared/lvl_cfg.svh
`ifndef LVL_CFG_SVH
`define LVL_CFG_SVH

`define OFS_SOFT_LVL 8'h80
`define OFS_VME_LVL 8'h84
`define OFS_VEC_IO 8'h88
`define OFS_MISC 8'h8C

`define LVL_USED 8'h77
`define POS_LVL_LO 0
`define POS_LVL_HI 4
`define POS_VBR0 28
`define POS_VBR1 24
`define POS_MASTER_IRQ_ENABLE 23
`define POS_SYSFAIL_LINE_STATE 22
`define POS_ACFAIL_LINE_STATE 21
`define POS_GPDIR 16
`define POS_GPDRV 12
`define POS_GPSNS 8
`define POS_GPI 0
`define POS_GRANT_OFF 0
`define POS_FILT_ON 1
`define POS_SHORT_BUSY 2
`define POS_NO_EARLY 3

`define RST_BYTE 8'h00
`define RST_WORD 32'h0000_0000
`define RST_NIB 4'h0
`define RST_PINS 22'h2001FF

`define CLK_NS 10
`define BUSY_SHORT_NS 90
`define BUSY_SHORT_MIN 3
`define BUSY_SHORT_CYC ((`BUSY_SHORT_NS + `CLK_NS - 1) / `CLK_NS)
`define BUSY_LONG_CYC 32

`endif

//--- shared/lvl_pkg.sv
package lvl_pkg;
    typedef logic [2:0] level_t;
    typedef logic [5:0] busy_cnt_t;
    typedef enum logic [1:0] {
        BH_IDLE = 2'b00,
        BH_RETRY = 2'b01,
        BH_HOLD = 2'b10,
        BH_OWN = 2'b11
    } busy_state_t;
endpackage

//--- shared/busy_ctl_if.sv
`timescale 1ns/1ps
interface busy_ctl_if;
    logic short_hold;
    logic no_early;
    logic grant;
    logic lb_vme_req;
    logic vme_slv_req;
    logic own_as;
    logic retry;
    logic bbsy_drive;
    logic holding;
    modport ctrl (output short_hold, no_early, grant, lb_vme_req, vme_slv_req, own_as,
                  input retry, bbsy_drive, holding);
    modport arb (input short_hold, no_early, grant, lb_vme_req, vme_slv_req, own_as,
                 output retry, bbsy_drive, holding);
endinterface

//--- design/irq_level_router.sv
`timescale 1ns/1ps
`include "lvl_cfg.svh"
module irq_level_router
    import lvl_pkg::*;
(
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_b,
    // Control.
    input wire logic filter_on,
    input wire logic master_en,
    // Sources and their levels.
    input wire logic [9:0] src,
    input wire level_t [9:0] lvls,
    // Requests per local level.
    output logic [7:1] irq_req_q
);
    logic [9:0] prev_q;
    logic [9:0] prev_d;
    logic [7:1] irq_req_d;
    logic [9:0] eff;

    // With the filter on a source must be seen on two samples in a row.
    always_comb begin
        prev_d = src;
        eff = filter_on ? (src & prev_q) : src;
        irq_req_d = 7'h00;
        for (int i = 0; i < 10; i++) begin
            if (master_en && eff[i] && lvls[i] != 3'h0) begin
                irq_req_d[lvls[i]] = 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            prev_q <= 10'h000;
            irq_req_q <= 7'h00;
        end else begin
            prev_q <= prev_d;
            irq_req_q <= irq_req_d;
        end
    end

    chk_mask_all_off: assert property (@(posedge clk) disable iff (!rst_b)
        !master_en |=> irq_req_q == 7'h00) else $error("request while masked");
    chk_zero_level_quiet: assert property (@(posedge clk) disable iff (!rst_b)
        (master_en && lvls == '0) |=> irq_req_q == 7'h00)
        else $error("level zero source raised a request");
    chk_route_level: assert property (@(posedge clk) disable iff (!rst_b)
        (master_en && !filter_on && src[4] && lvls[4] == 3'h5) |=> irq_req_q[5])
        else $error("line not routed to its level");
endmodule

//--- design/busy_hold.sv
`timescale 1ns/1ps
`include "lvl_cfg.svh"
module busy_hold
    import lvl_pkg::*;
(
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_b,
    // Arbitration controls.
    busy_ctl_if.arb bc
);
    localparam busy_cnt_t SHORT_LOAD = busy_cnt_t'(`BUSY_SHORT_CYC - 1);
    localparam busy_cnt_t LONG_LOAD = busy_cnt_t'(`BUSY_LONG_CYC - 1);

    busy_state_t state_q;
    busy_state_t state_d;
    busy_cnt_t cnt_q;
    busy_cnt_t cnt_d;

    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        unique case (state_q)
            BH_IDLE: begin
                if (bc.lb_vme_req && bc.vme_slv_req) begin
                    state_d = BH_RETRY;
                end else if (bc.lb_vme_req && bc.grant) begin
                    state_d = BH_OWN;
                end
            end
            BH_RETRY: begin
                if (bc.grant) begin
                    state_d = BH_HOLD;
                    cnt_d = bc.short_hold ? SHORT_LOAD : LONG_LOAD;
                end else if (!bc.vme_slv_req) begin
                    state_d = BH_IDLE;
                end
            end
            BH_HOLD: begin
                if (bc.lb_vme_req && !bc.vme_slv_req) begin
                    state_d = BH_OWN;
                end else if (cnt_q == 6'h00) begin
                    state_d = BH_IDLE;
                end else begin
                    cnt_d = cnt_q - 6'h01;
                end
            end
            BH_OWN: begin
                if (!bc.lb_vme_req) begin
                    state_d = BH_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            state_q <= BH_IDLE;
            cnt_q <= 6'h00;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
        end
    end

    assign bc.retry = state_q == BH_RETRY;
    assign bc.holding = state_q == BH_HOLD;
    // Busy stays while held or owned; with early release off it also follows our strobe.
    assign bc.bbsy_drive = bc.holding || state_q == BH_OWN || (bc.no_early && bc.own_as);

    sequence hold_entry_s;
        state_q == BH_RETRY && bc.grant;
    endsequence

    chk_deadlock_retry: assert property (@(posedge clk) disable iff (!rst_b)
        (state_q == BH_IDLE && bc.lb_vme_req && bc.vme_slv_req) |=> bc.retry)
        else $error("deadlock not answered with retry");
    chk_long_hold: assert property (@(posedge clk) disable iff (!rst_b)
        (hold_entry_s and !bc.short_hold) |=> cnt_q == 6'd31 && bc.bbsy_drive)
        else $error("long busy hold not loaded");
    chk_short_hold: assert property (@(posedge clk) disable iff (!rst_b)
        (hold_entry_s and bc.short_hold) |=> cnt_q == 6'd8 && bc.bbsy_drive)
        else $error("short busy hold not loaded");
    chk_no_early_bbsy: assert property (@(posedge clk) disable iff (!rst_b)
        (bc.no_early && bc.own_as) |-> bc.bbsy_drive) else $error("busy released early");
endmodule

//--- design/local_irq_level_ctrl.sv
// Function
// - Software 0 and 1 levels at 0x80
// - VME request 1-7 levels at 0x84, routed
// - Spare source level in top byte 0x84
// - Two 3-bit levels per byte, reset zero
// - Base vectors zero and one, bits 31-24
// - Master enable bit 23 masks everything
// - Bit 21 mirrors active fail-on-ac line
// - Bit 22 mirrors active system-fail line
// - Bits 16-19 general pin direction, reset zero
// - Bits 12-15 pin drive, 8-11 pin state
// - Low byte 0x88 reads eight input pins
// - Misc bit 0 turns grant filter off
// - Misc bit 1 turns interrupt filter on
// - Retried hold busy 32 or 9 clocks
// - Deadlock detected, local master told retry
// - Short hold about 90 ns, then release
// - Clear bit keeps busy 32 clocks
// - Bit 3 disables early busy release
// - Power, system, local resets per field
`timescale 1ns/1ps
`include "lvl_cfg.svh"
module local_irq_level_ctrl
    import lvl_pkg::*;
(
    // Clock and resets.
    input wire logic clk,
    input wire logic rst_b,
    input wire logic sys_reset_req,
    input wire logic local_reset_req,
    // Local register port.
    input wire logic lb_sel,
    input wire logic lb_wr,
    input wire logic [3:0] lb_be,
    input wire logic [7:0] lb_addr,
    input wire logic [31:0] lb_wdata,
    output logic [31:0] lb_rdata_q,
    output logic lb_ack_q,
    // Interrupt sources.
    input wire logic [1:0] soft_pend,
    input wire logic spare_pend,
    input wire logic [7:1] vme_irq_b,
    output logic [7:1] local_irq_req,
    // Fail lines.
    input wire logic acfail_b,
    input wire logic sysfail_b,
    // General purpose pins.
    input wire logic [3:0] gp_pin_in,
    output logic [3:0] gp_pin_out,
    output logic [3:0] gp_pin_oe,
    input wire logic [7:0] gp_input,
    // Bus arbitration.
    input wire logic bus_grant_b,
    input wire logic lb_vme_req,
    input wire logic vme_slv_req,
    input wire logic own_as,
    output logic lb_retry,
    output logic bbsy_drive,
    output logic busy_holding
);
    localparam int NSYNC = 22;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        hit = a[7:2] == ofs[7:2];
    endfunction

    // Pin synchroniser: only the second stage is read.
    logic [NSYNC-1:0] sync1_q;
    logic [NSYNC-1:0] sync2_q;
    logic [NSYNC-1:0] pins_raw;

    assign pins_raw = {bus_grant_b, gp_input, gp_pin_in, sysfail_b, acfail_b, vme_irq_b};

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            sync1_q <= `RST_PINS;
            sync2_q <= `RST_PINS;
        end else begin
            sync1_q <= pins_raw;
            sync2_q <= sync1_q;
        end
    end

    logic [7:1] vme_irq_act;
    logic acfail_act;
    logic sysfail_act;
    logic [3:0] gp_sense;
    logic [7:0] gpi_state;
    logic grant_act;

    assign vme_irq_act = ~sync2_q[6:0];
    assign acfail_act = ~sync2_q[7];
    assign sysfail_act = ~sync2_q[8];
    assign gp_sense = sync2_q[12:9];
    assign gpi_state = sync2_q[20:13];
    assign grant_act = ~sync2_q[21];

    // Register state.
    logic [7:0] soft_lvl_q;
    logic [7:0] soft_lvl_d;
    logic [31:0] vme_lvl_q;
    logic [31:0] vme_lvl_d;
    logic [7:0] vbr_q;
    logic [7:0] vbr_d;
    logic master_irq_enable_q;
    logic master_irq_enable_d;
    logic [3:0] gp_dir_q;
    logic [3:0] gp_dir_d;
    logic [3:0] gp_drv_q;
    logic [3:0] gp_drv_d;
    logic [7:0] misc_q;
    logic [7:0] misc_d;
    logic wr_en;

    assign wr_en = lb_sel && lb_wr;

    always_comb begin
        soft_lvl_d = soft_lvl_q;
        vme_lvl_d = vme_lvl_q;
        vbr_d = vbr_q;
        master_irq_enable_d = master_irq_enable_q;
        gp_dir_d = gp_dir_q;
        gp_drv_d = gp_drv_q;
        misc_d = misc_q;
        if (wr_en) begin
            if (hit(lb_addr, `OFS_SOFT_LVL) && lb_be[0]) begin
                soft_lvl_d = lb_wdata[7:0] & `LVL_USED;
            end
            if (hit(lb_addr, `OFS_VME_LVL)) begin
                for (int b = 0; b < 4; b++) begin
                    if (lb_be[b]) begin
                        vme_lvl_d[8*b +: 8] = lb_wdata[8*b +: 8] & `LVL_USED;
                    end
                end
            end
            if (hit(lb_addr, `OFS_VEC_IO)) begin
                if (lb_be[3]) begin
                    vbr_d = lb_wdata[31:24];
                end
                if (lb_be[2]) begin
                    master_irq_enable_d = lb_wdata[`POS_MASTER_IRQ_ENABLE];
                    gp_dir_d = lb_wdata[`POS_GPDIR +: 4];
                end
                if (lb_be[1]) begin
                    gp_drv_d = lb_wdata[`POS_GPDRV +: 4];
                end
            end
            if (hit(lb_addr, `OFS_MISC) && lb_be[0]) begin
                misc_d = lb_wdata[7:0];
            end
        end
        // Fields marked power, system and local are cleared by either later reset.
        if (sys_reset_req || local_reset_req) begin
            soft_lvl_d = `RST_BYTE;
            vme_lvl_d = `RST_WORD;
            vbr_d = `RST_BYTE;
            master_irq_enable_d = 1'b0;
            gp_drv_d[0] = 1'b0;
            misc_d[7:5] = 3'h0;
        end
        // Fields marked power and system only survive a local reset.
        if (sys_reset_req) begin
            gp_dir_d = `RST_NIB;
            gp_drv_d[3:1] = 3'h0;
            misc_d[4:0] = 5'h00;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            soft_lvl_q <= `RST_BYTE;
            vme_lvl_q <= `RST_WORD;
            vbr_q <= `RST_BYTE;
            master_irq_enable_q <= 1'b0;
            gp_dir_q <= `RST_NIB;
            gp_drv_q <= `RST_NIB;
            misc_q <= `RST_BYTE;
        end else begin
            soft_lvl_q <= soft_lvl_d;
            vme_lvl_q <= vme_lvl_d;
            vbr_q <= vbr_d;
            master_irq_enable_q <= master_irq_enable_d;
            gp_dir_q <= gp_dir_d;
            gp_drv_q <= gp_drv_d;
            misc_q <= misc_d;
        end
    end

    // The pins are unconnected on this board; the fields still drive them.
    assign gp_pin_oe = gp_dir_q;
    assign gp_pin_out = gp_drv_q;

    // Read path.
    logic [31:0] rdata_d;
    logic [31:0] vec_io_word;

    assign vec_io_word = {vbr_q, master_irq_enable_q, sysfail_act, acfail_act, 1'b0,
                          gp_dir_q, gp_drv_q, gp_sense, gpi_state};

    always_comb begin
        rdata_d = 32'h0000_0000;
        if (lb_sel && !lb_wr) begin
            if (hit(lb_addr, `OFS_SOFT_LVL)) begin
                rdata_d = {24'h000000, soft_lvl_q};
            end else if (hit(lb_addr, `OFS_VME_LVL)) begin
                rdata_d = vme_lvl_q;
            end else if (hit(lb_addr, `OFS_VEC_IO)) begin
                rdata_d = vec_io_word;
            end else if (hit(lb_addr, `OFS_MISC)) begin
                rdata_d = {24'h000000, misc_q};
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            lb_rdata_q <= `RST_WORD;
            lb_ack_q <= 1'b0;
        end else begin
            lb_rdata_q <= rdata_d;
            lb_ack_q <= lb_sel;
        end
    end

    // Level fields per source: soft 0-1, VME request 1-7, spare.
    level_t [9:0] lvls;

    assign lvls[0] = soft_lvl_q[`POS_LVL_LO +: 3];
    assign lvls[1] = soft_lvl_q[`POS_LVL_HI +: 3];
    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_vme_lvl
            assign lvls[2*g+2] = vme_lvl_q[8*g + `POS_LVL_LO +: 3];
            if (g < 3) begin : g_hi
                assign lvls[2*g+3] = vme_lvl_q[8*g + `POS_LVL_HI +: 3];
            end
        end
    endgenerate
    assign lvls[9] = vme_lvl_q[24 + `POS_LVL_HI +: 3];

    irq_level_router u_router (
        .clk(clk),
        .rst_b(rst_b),
        .filter_on(misc_q[`POS_FILT_ON]),
        .master_en(master_irq_enable_q),
        .src({spare_pend, vme_irq_act, soft_pend}),
        .lvls(lvls),
        .irq_req_q(local_irq_req)
    );

    // Grant filter: two agreeing samples unless turned off.
    logic grant_prev_q;
    logic grant_prev_d;
    logic grant_eff;

    always_comb begin
        grant_prev_d = grant_act;
        grant_eff = misc_q[`POS_GRANT_OFF] ? grant_act : (grant_act && grant_prev_q);
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            grant_prev_q <= 1'b0;
        end else begin
            grant_prev_q <= grant_prev_d;
        end
    end

    busy_ctl_if bc ();

    assign bc.short_hold = misc_q[`POS_SHORT_BUSY];
    assign bc.no_early = misc_q[`POS_NO_EARLY];
    assign bc.grant = grant_eff;
    assign bc.lb_vme_req = lb_vme_req;
    assign bc.vme_slv_req = vme_slv_req;
    assign bc.own_as = own_as;

    busy_hold u_busy (
        .clk(clk),
        .rst_b(rst_b),
        .bc(bc.arb)
    );

    assign lb_retry = bc.retry;
    assign bbsy_drive = bc.bbsy_drive;
    assign busy_holding = bc.holding;

    chk_acfail_mirror: assert property (@(posedge clk) disable iff (!rst_b)
        (lb_sel && !lb_wr && hit(lb_addr, `OFS_VEC_IO)) |=>
        lb_rdata_q[`POS_ACFAIL_LINE_STATE] == $past(acfail_act)) else $error("ac fail bit wrong");
    chk_sysfail_mirror: assert property (@(posedge clk) disable iff (!rst_b)
        (lb_sel && !lb_wr && hit(lb_addr, `OFS_VEC_IO)) |=>
        lb_rdata_q[`POS_SYSFAIL_LINE_STATE] == $past(sysfail_act)) else $error("sys fail bit wrong");
    chk_level_reset: assert property (@(posedge clk) disable iff (!rst_b)
        local_reset_req |=> soft_lvl_q == 8'h00 && vme_lvl_q == 32'h0000_0000 && !master_irq_enable_q)
        else $error("local reset left a level field");
    chk_local_keeps_dir: assert property (@(posedge clk) disable iff (!rst_b)
        (local_reset_req && !sys_reset_req && !wr_en) |=> $stable(gp_dir_q))
        else $error("local reset touched pin direction");
    chk_vbr_write: assert property (@(posedge clk) disable iff (!rst_b)
        (wr_en && hit(lb_addr, `OFS_VEC_IO) && lb_be[3] && !sys_reset_req && !local_reset_req)
        |=> vbr_q == $past(lb_wdata[31:24])) else $error("vector base not written");
    chk_unused_bits: assert property (@(posedge clk) disable iff (!rst_b)
        (soft_lvl_q & 8'h88) == 8'h00 && (vme_lvl_q & 32'h8888_8888) == 32'h0)
        else $error("unused level bit set");
endmodule

//--- dv/vme_far_end.sv
`timescale 1ns/1ps
module vme_far_end (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_b,
    // Commands from the bench.
    input wire logic [7:1] irq_on,
    input wire logic ac_on,
    input wire logic sys_on,
    input wire logic slv_on,
    input wire logic grant_on,
    // Lines seen by the block.
    input wire logic bbsy_drive,
    output logic [7:1] vme_irq_b,
    output logic acfail_b,
    output logic sysfail_b,
    output logic vme_slv_req,
    output logic bus_grant_b
);
    logic used_q;

    // Released open-collector lines rest at their pull-up level.
    // A grant is given once per request and withdrawn as soon as busy is taken.
    always @(posedge clk) begin
        vme_irq_b <= ~irq_on;
        acfail_b <= ~ac_on;
        sysfail_b <= ~sys_on;
        vme_slv_req <= slv_on;
        if (!rst_b || !grant_on) begin
            bus_grant_b <= 1'b1;
            used_q <= 1'b0;
        end else if (bbsy_drive) begin
            bus_grant_b <= 1'b1;
            used_q <= 1'b1;
        end else if (!used_q) begin
            bus_grant_b <= 1'b0;
        end
    end
endmodule

//--- dv/test_local_irq_level_and_bus_misc_ctrl.sv
`timescale 1ns/1ps
`include "lvl_cfg.svh"
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin err_total++; \
    $display("wrong value at %0t: got %h expected %h", $time, (g), (e)); end end
module test_local_irq_level_and_bus_misc_ctrl;
    logic clk, rst_b, sys_reset_req, local_reset_req, lb_sel, lb_wr, lb_ack_q;
    logic [3:0] lb_be, gp_pin_in, gp_pin_out, gp_pin_oe;
    logic [7:0] lb_addr, gp_input;
    logic [31:0] lb_wdata, lb_rdata_q;
    logic [1:0] soft_pend;
    logic [7:1] vme_irq_b, local_irq_req, irq_on;
    logic spare_pend, acfail_b, sysfail_b, bus_grant_b, lb_vme_req, vme_slv_req;
    logic own_as, lb_retry, bbsy_drive, busy_holding, ac_on, sys_on, slv_on, grant_on;
    int err_total, tests_run, l0, l1, l2;

    local_irq_level_ctrl dut (
        .clk, .rst_b, .sys_reset_req, .local_reset_req, .lb_sel, .lb_wr, .lb_be, .lb_addr,
        .lb_wdata, .lb_rdata_q, .lb_ack_q, .soft_pend, .spare_pend, .vme_irq_b, .local_irq_req,
        .acfail_b, .sysfail_b, .gp_pin_in, .gp_pin_out, .gp_pin_oe, .gp_input, .bus_grant_b,
        .lb_vme_req, .vme_slv_req, .own_as, .lb_retry, .bbsy_drive, .busy_holding
    );
    vme_far_end far (
        .clk, .rst_b, .irq_on, .ac_on, .sys_on, .slv_on, .grant_on, .bbsy_drive, .vme_irq_b,
        .acfail_b, .sysfail_b, .vme_slv_req, .bus_grant_b
    );

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic tick(inout int n);
        @(posedge clk);
        #1;
        n++;
    endtask

    // The select is a one-cycle pulse; the answer stands only in the next cycle.
    task automatic bus(input logic wr, input logic [7:0] a, input logic [3:0] be,
                       input logic [31:0] d, output logic [31:0] q);
        @(posedge clk);
        lb_sel <= 1'b1;
        lb_wr <= wr;
        lb_addr <= a;
        lb_be <= be;
        lb_wdata <= d;
        @(posedge clk);
        lb_sel <= 1'b0;
        #1;
        q = lb_rdata_q;
        `CHK(lb_ack_q, 1'b1)
    endtask

    task automatic reg_wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, be, d, q);
    endtask

    task automatic reg_rd(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, a, 4'hF, 32'h0, q);
        `CHK(q, e)
    endtask

    task automatic wait_req(input logic [7:1] e, output int n);
        n = 0;
        do tick(n); while (local_irq_req !== e && n < 8);
    endtask

    task automatic test_reset_vals;
        reg_rd(`OFS_SOFT_LVL, 32'h0);
        reg_rd(`OFS_VME_LVL, 32'h0);
        reg_rd(`OFS_VEC_IO, 32'h0);
        reg_rd(`OFS_MISC, 32'h0);
        $display("test reset_vals done");
    endtask

    task automatic test_reg_rw;
        reg_wr(`OFS_SOFT_LVL, 4'hF, 32'hFFFF_FFFF);
        reg_rd(`OFS_SOFT_LVL, 32'h0000_0077);
        reg_wr(`OFS_VME_LVL, 4'hF, 32'hFFFF_FFFF);
        reg_rd(`OFS_VME_LVL, 32'h7777_7777);
        reg_wr(`OFS_VME_LVL, 4'h8, 32'h5000_0000);
        reg_rd(`OFS_VME_LVL, 32'h5077_7777);
        reg_wr(`OFS_MISC, 4'h1, 32'h0000_007F);
        reg_rd(`OFS_MISC, 32'h0000_007F);
        reg_wr(8'h90, 4'hF, 32'hFFFF_FFFF);
        reg_rd(8'h90, 32'h0);
        reg_wr(`OFS_MISC, 4'h1, 32'h0);
        reg_wr(`OFS_SOFT_LVL, 4'h1, 32'h0);
        $display("test reg_rw done");
    endtask

    task automatic test_status;
        reg_wr(`OFS_VEC_IO, 4'h6, 32'h0005_9000);
        @(posedge clk);
        ac_on <= 1'b1;
        gp_pin_in <= 4'hA;
        gp_input <= 8'h5C;
        repeat (5) @(posedge clk);
        reg_rd(`OFS_VEC_IO, 32'h0025_9A5C);
        @(posedge clk);
        ac_on <= 1'b0;
        sys_on <= 1'b1;
        repeat (5) @(posedge clk);
        reg_rd(`OFS_VEC_IO, 32'h0045_9A5C);
        `CHK(gp_pin_oe, 4'h5)
        `CHK(gp_pin_out, 4'h9)
        @(posedge clk);
        sys_on <= 1'b0;
        $display("test status done");
    endtask

    task automatic test_routing;
        logic [7:1] e;
        int n;
        reg_wr(`OFS_VEC_IO, 4'h4, 32'h0080_0000);
        for (int k = 1; k < 8; k++) begin
            e = '0;
            e[8 - k] = 1'b1;
            reg_wr(`OFS_VME_LVL, 4'hF, 32'(8 - k) << (4 * (k - 1)));
            @(posedge clk);
            irq_on[k] <= 1'b1;
            wait_req(e, n);
            `CHK(local_irq_req, e)
            @(posedge clk);
            irq_on <= '0;
            repeat (4) @(posedge clk);
        end
        reg_wr(`OFS_VME_LVL, 4'hF, 32'h0);
        @(posedge clk);
        irq_on <= 7'h7F;
        spare_pend <= 1'b1;
        repeat (6) @(posedge clk);
        #1;
        `CHK(local_irq_req, 7'h00)
        reg_wr(`OFS_VME_LVL, 4'h8, 32'h2000_0000);
        @(posedge clk);
        irq_on <= '0;
        spare_pend <= 1'b0;
        repeat (5) @(posedge clk);
        spare_pend <= 1'b1;
        wait_req(7'h02, n);
        `CHK(n, 1)
        @(posedge clk);
        spare_pend <= 1'b0;
        reg_wr(`OFS_MISC, 4'h1, 32'h2);
        @(posedge clk);
        spare_pend <= 1'b1;
        wait_req(7'h02, n);
        `CHK(n, 2)
        reg_wr(`OFS_MISC, 4'h1, 32'h0);
        reg_wr(`OFS_VEC_IO, 4'h4, 32'h0);
        repeat (3) @(posedge clk);
        #1;
        `CHK(local_irq_req, 7'h00)
        reg_wr(`OFS_VEC_IO, 4'h4, 32'h0080_0000);
        reg_wr(`OFS_SOFT_LVL, 4'h1, 32'h64);
        @(posedge clk);
        spare_pend <= 1'b0;
        soft_pend <= 2'b11;
        wait_req(7'h28, n);
        `CHK(local_irq_req, 7'h28)
        @(posedge clk);
        soft_pend <= 2'b00;
        $display("test routing done");
    endtask

    task automatic test_resets;
        reg_wr(`OFS_VEC_IO, 4'hE, 32'hFF8F_F000);
        reg_wr(`OFS_SOFT_LVL, 4'h1, 32'h77);
        reg_wr(`OFS_MISC, 4'h1, 32'h6F);
        @(posedge clk);
        local_reset_req <= 1'b1;
        @(posedge clk);
        local_reset_req <= 1'b0;
        reg_rd(`OFS_VEC_IO, 32'h000F_EA5C);
        reg_rd(`OFS_SOFT_LVL, 32'h0);
        reg_rd(`OFS_MISC, 32'h0F);
        @(posedge clk);
        sys_reset_req <= 1'b1;
        @(posedge clk);
        sys_reset_req <= 1'b0;
        reg_rd(`OFS_VEC_IO, 32'h0000_0A5C);
        reg_rd(`OFS_MISC, 32'h0);
        $display("test resets done");
    endtask

    task automatic enter_hold(output int lat);
        int n;
        @(posedge clk);
        lb_vme_req <= 1'b1;
        slv_on <= 1'b1;
        n = 0;
        do tick(n); while (lb_retry !== 1'b1 && n < 8);
        `CHK(lb_retry, 1'b1)
        if (lb_retry !== 1'b1)
            tally_and_finish();
        @(posedge clk);
        grant_on <= 1'b1;
        lat = 0;
        do tick(lat); while (busy_holding !== 1'b1 && lat < 12);
        `CHK(busy_holding, 1'b1)
        if (busy_holding !== 1'b1)
            tally_and_finish();
    endtask

    task automatic release_all;
        @(posedge clk);
        lb_vme_req <= 1'b0;
        slv_on <= 1'b0;
        grant_on <= 1'b0;
        repeat (4) @(posedge clk);
        #1;
        `CHK(bbsy_drive, 1'b0)
    endtask

    task automatic test_hold(input logic [7:0] misc, input int exp, output int lat);
        int n;
        reg_wr(`OFS_MISC, 4'h1, {24'h0, misc});
        enter_hold(lat);
        `CHK(bbsy_drive, 1'b1)
        n = 1;
        do tick(n); while (busy_holding === 1'b1 && n < 40);
        `CHK(n - 1, exp)
        release_all();
        $display("test hold done");
    endtask

    task automatic test_return;
        int n;
        reg_wr(`OFS_MISC, 4'h1, 32'h4);
        enter_hold(n);
        @(posedge clk);
        slv_on <= 1'b0;
        n = 0;
        do tick(n); while (busy_holding === 1'b1 && n < 8);
        repeat (2) @(posedge clk);
        #1;
        `CHK({busy_holding, bbsy_drive}, 2'b01)
        release_all();
        enter_hold(n);
        n = 0;
        do tick(n); while (busy_holding === 1'b1 && n < 12);
        @(posedge clk);
        slv_on <= 1'b0;
        repeat (3) @(posedge clk);
        #1;
        `CHK(bbsy_drive, 1'b0)
        release_all();
        reg_wr(`OFS_MISC, 4'h1, 32'h8);
        @(posedge clk);
        own_as <= 1'b1;
        tick(n);
        `CHK(bbsy_drive, 1'b1)
        reg_wr(`OFS_MISC, 4'h1, 32'h0);
        tick(n);
        `CHK(bbsy_drive, 1'b0)
        @(posedge clk);
        own_as <= 1'b0;
        $display("test return done");
    endtask

    initial begin
        {sys_reset_req, local_reset_req, lb_sel, lb_wr, spare_pend, lb_vme_req, own_as} = '0;
        {ac_on, sys_on, slv_on, grant_on} = '0;
        lb_be = '0;
        lb_addr = '0;
        lb_wdata = '0;
        soft_pend = '0;
        irq_on = '0;
        gp_pin_in = '0;
        gp_input = '0;
        rst_b = 1'b0;
        repeat (8) @(posedge clk);
        rst_b <= 1'b1;
        test_reset_vals();
        test_reg_rw();
        test_status();
        test_routing();
        test_resets();
        test_hold(8'h00, `BUSY_LONG_CYC, l0);
        test_hold(8'h04, `BUSY_SHORT_CYC, l1);
        test_hold(8'h05, `BUSY_SHORT_CYC, l2);
        `CHK(l2 < l1, 1'b1)
        test_return();
        tally_and_finish();
    end
endmodule
